/* core/dsc_core.sv */
// Purpose: demodulator, timer divider and sync/length configuration
// Assumes: ref_en pulses at the 13.56 MHz reference rate
// Notes: packet verdicts are pulses, data are not buffered
`timescale 1ns/1ps
module dsc_core #(
    parameter int STR_W = 8,
    parameter int DIV_W = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // mode inputs
    input wire logic sync_detect_enable,
    input wire logic rate_106k,
    input wire logic secure_core_link,
    // demodulator side
    input wire logic [STR_W-1:0] i_strength,
    input wire logic [STR_W-1:0] q_strength,
    input wire logic rx_active,
    output dsc_pkg::dsc_chan_t chan_sel,
    output logic [1:0] secure_link_cfg,
    output logic pll_freeze,
    output logic [1:0] pll_rx_time_const,
    // timer prescaler
    input wire logic ref_en,
    input wire logic [DIV_W-1:0] timer_divider_value,
    output logic timer_tick,
    // sync preamble
    input wire logic [2:0] sync_byte_idx,
    output logic [2:0] sync_byte_count,
    output logic [7:0] sync_byte,
    // frame decoder
    input wire dsc_pkg::dsc_rx_t rx_in,
    output logic packet_accept,
    output logic packet_drop
);
    localparam int PER_W = DIV_W + 2;
    localparam logic [8:0] CNT_MAX = 9'h1ff;

    logic [7:0] demod_reg;
    logic [7:0] sync_reg;
    logic [1:0] iq_combine_sel;
    logic iq_channel_lock;
    logic lock_eff;
    logic timer_divider_even;
    logic [1:0] sync_preamble_len;
    logic [5:0] min_packet_len;
    logic rx_active_reg;
    logic frozen_q_reg;
    logic dropped_reg;
    logic q_stronger;
    logic [PER_W-1:0] period;
    logic [PER_W-1:0] div_cnt_reg;
    logic [8:0] byte_cnt_reg;
    logic [8:0] byte_cnt_next;
    logic [8:0] min_bytes;
    logic check_on;

    ////////////////////////////////////////////////////////////////
    // field extraction
    assign iq_combine_sel = demod_reg[dsc_pkg::IQ_SEL_HI:dsc_pkg::IQ_SEL_LO];
    assign iq_channel_lock = demod_reg[dsc_pkg::IQ_LOCK_BIT];
    assign timer_divider_even = demod_reg[dsc_pkg::DIV_EVEN_BIT];
    assign pll_rx_time_const = demod_reg[dsc_pkg::TAU_HI:dsc_pkg::TAU_LO];
    assign sync_preamble_len =
        sync_reg[dsc_pkg::SYNC_LEN_HI:dsc_pkg::SYNC_LEN_LO];
    assign min_packet_len =
        sync_reg[dsc_pkg::MIN_LEN_HI:dsc_pkg::MIN_LEN_LO];

    ////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            demod_reg <= dsc_pkg::DEMOD_RST;
            sync_reg <= dsc_pkg::SYNC_RST;
        end else if (reg_wr) begin
            if (reg_addr == dsc_pkg::DEMOD_OFS) begin
                demod_reg <= reg_wdata;
            end
            if (reg_addr == dsc_pkg::SYNC_OFS) begin
                sync_reg <= reg_wdata;
            end
        end
    end

    // read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                dsc_pkg::DEMOD_OFS: reg_rdata <= demod_reg;
                dsc_pkg::SYNC_OFS: reg_rdata <= sync_reg;
                dsc_pkg::STAT_OFS: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[dsc_pkg::ST_FROZEN_Q] <= frozen_q_reg;
                    reg_rdata[dsc_pkg::ST_DROPPED] <= dropped_reg;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // channel selection
    assign lock_eff = iq_channel_lock | secure_core_link;
    assign q_stronger = q_strength > i_strength;
    assign secure_link_cfg = secure_core_link ? iq_combine_sel : 2'b00;

    // freeze the stronger channel at the start of a communication
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_active_reg <= 1'b0;
            frozen_q_reg <= 1'b0;
        end else begin
            rx_active_reg <= rx_active;
            if (rx_active && !rx_active_reg) begin
                frozen_q_reg <= q_stronger;
            end
        end
    end

    // registered choice handed to the demodulator
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chan_sel <= '0;
        end else if (secure_core_link) begin
            chan_sel <= '0;
        end else if (lock_eff) begin
            chan_sel.combine <= 1'b0;
            chan_sel.use_q <= iq_combine_sel[0];
        end else begin
            unique case (iq_combine_sel)
                dsc_pkg::IQ_STRONGER: begin
                    chan_sel.combine <= 1'b0;
                    chan_sel.use_q <= q_stronger;
                end
                dsc_pkg::IQ_FREEZE: begin
                    chan_sel.combine <= 1'b0;
                    chan_sel.use_q <= (rx_active && rx_active_reg) ?
                        frozen_q_reg : q_stronger;
                end
                dsc_pkg::IQ_COMBINE: begin
                    chan_sel.combine <= 1'b1;
                    chan_sel.use_q <= 1'b0;
                end
                default: begin
                    chan_sel <= '0; // reserved code, hold on I
                end
            endcase
        end
    end

    // pll hold while receiving with the frozen time constant code
    assign pll_freeze = rx_active &&
        (pll_rx_time_const == dsc_pkg::TAU_FROZEN);

    ////////////////////////////////////////////////////////////////
    // timer prescaler: ratio 2N+1 or 2N+2 reference pulses
    assign period = {1'b0, timer_divider_value, 1'b0}
        + PER_W'(1) + PER_W'(timer_divider_even);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_cnt_reg <= '0;
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= 1'b0;
            if (ref_en) begin
                if (div_cnt_reg >= period - PER_W'(1)) begin
                    div_cnt_reg <= '0;
                    timer_tick <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + PER_W'(1);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sync preamble: leading zero bytes then the two sync bytes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_byte_count <= 3'h0;
            sync_byte <= 8'h00;
        end else begin
            sync_byte_count <= {1'b0, sync_preamble_len} + 3'h2;
            if (sync_byte_idx < {1'b0, sync_preamble_len}) begin
                sync_byte <= dsc_pkg::SYNC_PAD;
            end else if (sync_byte_idx == {1'b0, sync_preamble_len}) begin
                sync_byte <= dsc_pkg::SYNC_B0;
            end else begin
                sync_byte <= dsc_pkg::SYNC_B1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // packet length filter
    assign min_bytes = 9'(min_packet_len) * 9'(dsc_pkg::MIN_LEN_SCALE);
    assign check_on = !(rate_106k && !sync_detect_enable);
    assign byte_cnt_next = (byte_cnt_reg == CNT_MAX) ?
        byte_cnt_reg : byte_cnt_reg + 9'h001;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            byte_cnt_reg <= '0;
            packet_accept <= 1'b0;
            packet_drop <= 1'b0;
        end else begin
            packet_accept <= 1'b0;
            packet_drop <= 1'b0;
            if (rx_in.valid) begin
                if (rx_in.last) begin
                    byte_cnt_reg <= '0;
                    if (!check_on || byte_cnt_next >= min_bytes) begin
                        packet_accept <= 1'b1;
                    end else begin
                        packet_drop <= 1'b1;
                    end
                end else begin
                    byte_cnt_reg <= byte_cnt_next;
                end
            end
        end
    end

    // sticky record of a dropped packet, cleared by status read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dropped_reg <= 1'b0;
        end else if (packet_drop) begin
            dropped_reg <= 1'b1;
        end else if (reg_rd && reg_addr == dsc_pkg::STAT_OFS) begin
            dropped_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    logic [PER_W-1:0] en_seen;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_seen <= '0;
        end else if (timer_tick) begin
            en_seen <= PER_W'(ref_en); // pulse taken with the tick opens a period
        end else if (ref_en) begin
            en_seen <= en_seen + PER_W'(1);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_stronger;
        !lock_eff && iq_combine_sel == dsc_pkg::IQ_STRONGER
            |=> chan_sel.use_q == $past(q_stronger);
    endproperty
    a_stronger: assert property (p_stronger)
        else $error("stronger channel not tracked");

    property p_freeze;
        !lock_eff && iq_combine_sel == dsc_pkg::IQ_FREEZE
            && rx_active && rx_active_reg
            |=> chan_sel.use_q == $past(frozen_q_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen channel changed");

    property p_combine;
        !lock_eff && iq_combine_sel == dsc_pkg::IQ_COMBINE
            |=> chan_sel.combine;
    endproperty
    a_combine: assert property (p_combine)
        else $error("combine not selected");

    property p_lock;
        lock_eff |=> !chan_sel.combine;
    endproperty
    a_lock: assert property (p_lock)
        else $error("combine active while locked");

    property p_fix_i;
        iq_channel_lock && !secure_core_link && !iq_combine_sel[0]
            |=> !chan_sel.use_q;
    endproperty
    a_fix_i: assert property (p_fix_i)
        else $error("locked I not used");

    property p_fix_q;
        iq_channel_lock && !secure_core_link && iq_combine_sel[0]
            |=> chan_sel.use_q;
    endproperty
    a_fix_q: assert property (p_fix_q)
        else $error("locked Q not used");

    property p_link;
        secure_core_link |-> secure_link_cfg == iq_combine_sel
            ##1 chan_sel == '0;
    endproperty
    a_link: assert property (p_link)
        else $error("secure link routing wrong");

    property p_tick;
        timer_tick && $past(period) == $past(period, 2)
            |-> en_seen == $past(period);
    endproperty
    a_tick: assert property (p_tick)
        else $error("timer tick spacing wrong");

    property p_pll;
        rx_active && pll_rx_time_const == dsc_pkg::TAU_FROZEN
            |-> pll_freeze;
    endproperty
    a_pll: assert property (p_pll)
        else $error("pll not frozen");

    property p_tau_wr;
        reg_wr && reg_addr == dsc_pkg::DEMOD_OFS |=> pll_rx_time_const
            == $past(reg_wdata[dsc_pkg::TAU_HI:dsc_pkg::TAU_LO]);
    endproperty
    a_tau_wr: assert property (p_tau_wr)
        else $error("time constant write lost");

    property p_short;
        rx_in.valid && rx_in.last && check_on
            && byte_cnt_next < min_bytes
            |=> packet_drop && !packet_accept;
    endproperty
    a_short: assert property (p_short)
        else $error("short packet accepted");

    property p_bypass;
        rx_in.valid && rx_in.last && !check_on |=> packet_accept;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("length check not skipped");

    c_freeze: cover property (rx_active && !rx_active_reg
        && iq_combine_sel == dsc_pkg::IQ_FREEZE);
    c_drop: cover property (packet_drop);
    c_accept: cover property (packet_accept && min_bytes != 9'h000);
    c_even: cover property (timer_tick && timer_divider_even);
endmodule : dsc_core

/* core/dsc_pkg.sv */
// Purpose: shared constants and types of the receive config block
// Assumes: 8-bit registers on a plain strobe port
// Notes: reset values load the documented defaults
package dsc_pkg;
    // register offsets
    localparam logic [7:0] DEMOD_OFS = 8'h19;
    localparam logic [7:0] SYNC_OFS = 8'h1a;
    localparam logic [7:0] STAT_OFS = 8'h3f;
    // reset values
    localparam logic [7:0] DEMOD_RST = 8'h4d;
    localparam logic [7:0] SYNC_RST = 8'h00;
    // demodulator field positions
    localparam int IQ_SEL_HI = 7;
    localparam int IQ_SEL_LO = 6;
    localparam int IQ_LOCK_BIT = 5;
    localparam int DIV_EVEN_BIT = 4;
    localparam int TAU_HI = 3;
    localparam int TAU_LO = 2;
    // sync config field positions
    localparam int SYNC_LEN_HI = 7;
    localparam int SYNC_LEN_LO = 6;
    localparam int MIN_LEN_HI = 5;
    localparam int MIN_LEN_LO = 0;
    // status field positions
    localparam int ST_FROZEN_Q = 0;
    localparam int ST_DROPPED = 1;
    // channel combine codes and the frozen time constant code
    localparam logic [1:0] IQ_STRONGER = 2'b00;
    localparam logic [1:0] IQ_FREEZE = 2'b01;
    localparam logic [1:0] IQ_COMBINE = 2'b10;
    localparam logic [1:0] TAU_FROZEN = 2'b00;
    // sync preamble bytes, min length scale and reference rate in kHz
    localparam logic [7:0] SYNC_B0 = 8'hb2;
    localparam logic [7:0] SYNC_B1 = 8'h4d;
    localparam logic [7:0] SYNC_PAD = 8'h00;
    localparam int MIN_LEN_SCALE = 4;
    localparam int REF_KHZ = 13560;

    // channel choice handed to the demodulator
    typedef struct packed {
        logic combine;
        logic use_q;
    } dsc_chan_t;

    // received byte stream from the frame decoder
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } dsc_rx_t;
endpackage : dsc_pkg

/* dv/dsc_core_tb.sv */
// Purpose: self-checking bench for the receive config block
// Assumes: strobe register port, read data one cycle after the strobe
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module dsc_core_tb;
    // clock, reset and register port
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    // mode and demodulator side
    logic sync_detect_enable = 1'b1;
    logic rate_106k = 1'b0;
    logic secure_core_link = 1'b0;
    logic [7:0] i_strength = 8'h10;
    logic [7:0] q_strength = 8'h20;
    logic rx_active = 1'b0;
    dsc_pkg::dsc_chan_t chan_sel;
    logic [1:0] secure_link_cfg;
    logic pll_freeze;
    logic [1:0] pll_rx_time_const;
    // timer, sync and frame side
    logic ref_en = 1'b0;
    logic [11:0] timer_divider_value = 12'h002;
    logic timer_tick;
    logic [2:0] sync_byte_idx = 3'h0;
    logic [2:0] sync_byte_count;
    logic [7:0] sync_byte;
    dsc_pkg::dsc_rx_t rx_in = '0;
    logic packet_accept;
    logic packet_drop;
    int failures = 0;
    int comparisons = 0;
    logic [7:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // clock and design
    always #12.5 ref_clk = ~ref_clk;

    dsc_core #(.STR_W(8), .DIV_W(12)) u_dsc_core (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sync_detect_enable(sync_detect_enable),
        .rate_106k(rate_106k), .secure_core_link(secure_core_link),
        .i_strength(i_strength), .q_strength(q_strength),
        .rx_active(rx_active), .chan_sel(chan_sel),
        .secure_link_cfg(secure_link_cfg), .pll_freeze(pll_freeze),
        .pll_rx_time_const(pll_rx_time_const), .ref_en(ref_en),
        .timer_divider_value(timer_divider_value), .timer_tick(timer_tick),
        .sync_byte_idx(sync_byte_idx), .sync_byte_count(sync_byte_count),
        .sync_byte(sync_byte), .rx_in(rx_in), .packet_accept(packet_accept),
        .packet_drop(packet_drop)
    );

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic complete_run;
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // let n edges land, then sample settled outputs
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        chk(rd_val, exp);
    endtask : rdchk

    function automatic logic [7:0] dm(input logic [1:0] sel,
        input logic lock, input logic even, input logic [1:0] tau);
        return {sel, lock, even, tau, 2'b01};
    endfunction : dm

    task automatic chan(input logic [1:0] sel, input logic lock,
        input logic [7:0] i, input logic [7:0] q, input logic [1:0] exp);
        wr(dsc_pkg::DEMOD_OFS, dm(sel, lock, 1'b0, 2'b01));
        @(posedge ref_clk);
        i_strength <= i;
        q_strength <= q;
        step(2);
        chk({6'h00, chan_sel}, {6'h00, exp});
    endtask : chan

    // bounded wait for the next tick; n counts cycles waited
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (timer_tick !== 1'b1 && n < 40);
        if (n >= 40) begin
            failures++;
            complete_run;
        end
    endtask : wait_tick

    task automatic timer_period(input logic even, input logic [7:0] exp);
        int n;
        wr(dsc_pkg::DEMOD_OFS, dm(2'b00, 1'b0, even, 2'b01));
        @(posedge ref_clk);
        ref_en <= 1'b1;
        wait_tick(n);
        wait_tick(n);
        chk(8'(n), exp);
        @(posedge ref_clk);
        ref_en <= 1'b0;
    endtask : timer_period

    // send n bytes, then look for exactly one kind of verdict
    task automatic pkt(input int n, input logic exp_acc);
        logic acc;
        logic drop;
        acc = 1'b0;
        drop = 1'b0;
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk);
            rx_in <= '{valid: 1'b1, last: (k == n - 1), data: 8'(k)};
        end
        @(posedge ref_clk);
        rx_in <= '0;
        repeat (4) begin
            #1;
            acc = acc | packet_accept;
            drop = drop | packet_drop;
            @(posedge ref_clk);
        end
        chk({6'h00, acc, drop}, {6'h00, exp_acc, !exp_acc});
    endtask : pkt

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rdchk(dsc_pkg::DEMOD_OFS, 8'h4d);
        rdchk(dsc_pkg::SYNC_OFS, 8'h00);
        chk({6'h00, pll_rx_time_const}, 8'h03);
        wr(8'h20, 8'hff);
        rdchk(8'h20, 8'h00);
        wr(dsc_pkg::SYNC_OFS, 8'hc5);
        rdchk(dsc_pkg::SYNC_OFS, 8'hc5);
    endtask : t_regs

    task automatic t_chan;
        chan(2'b00, 1'b0, 8'h10, 8'h20, 2'b01);
        chan(2'b00, 1'b0, 8'h30, 8'h20, 2'b00);
        chan(2'b10, 1'b0, 8'h30, 8'h20, 2'b10);
        chan(2'b11, 1'b0, 8'h10, 8'h20, 2'b00);
        chan(2'b01, 1'b1, 8'h40, 8'h20, 2'b01);
        chan(2'b10, 1'b1, 8'h10, 8'h20, 2'b00);
        // freeze on stronger q, then weaken q mid reception
        chan(2'b01, 1'b0, 8'h10, 8'h20, 2'b01);
        @(posedge ref_clk);
        rx_active <= 1'b1;
        step(2);
        @(posedge ref_clk);
        i_strength <= 8'h40;
        q_strength <= 8'h10;
        step(2);
        chk({6'h00, chan_sel}, 8'h01);
        rdchk(dsc_pkg::STAT_OFS, 8'h01);
        @(posedge ref_clk);
        rx_active <= 1'b0;
        step(2);
        chk({6'h00, chan_sel}, 8'h00);
    endtask : t_chan

    task automatic t_misc;
        @(posedge ref_clk);
        secure_core_link <= 1'b1;
        wr(dsc_pkg::DEMOD_OFS, dm(2'b10, 1'b1, 1'b0, 2'b01));
        step(2);
        chk({6'h00, secure_link_cfg, chan_sel}, 8'h08);
        @(posedge ref_clk);
        secure_core_link <= 1'b0;
        rx_active <= 1'b1;
        wr(dsc_pkg::DEMOD_OFS, dm(2'b00, 1'b0, 1'b0, 2'b00));
        step(1);
        chk({7'h00, pll_freeze}, 8'h01);
        wr(dsc_pkg::DEMOD_OFS, dm(2'b00, 1'b0, 1'b0, 2'b10));
        step(1);
        chk({5'h00, pll_freeze, pll_rx_time_const}, 8'h02);
        @(posedge ref_clk);
        rx_active <= 1'b0;
        timer_period(1'b0, 8'h05);
        timer_period(1'b1, 8'h06);
    endtask : t_misc

    task automatic t_sync;
        logic [7:0] e;
        for (int l = 0; l < 4; l++) begin
            wr(dsc_pkg::SYNC_OFS, {2'(l), 6'h00});
            for (int k = 0; k < l + 2; k++) begin
                @(posedge ref_clk);
                sync_byte_idx <= 3'(k);
                step(1);
                e = (k < l) ? dsc_pkg::SYNC_PAD :
                    (k == l) ? dsc_pkg::SYNC_B0 : dsc_pkg::SYNC_B1;
                chk(sync_byte, e);
            end
            chk({5'h00, sync_byte_count}, 8'(l + 2));
        end
    endtask : t_sync

    task automatic t_pkt;
        wr(dsc_pkg::SYNC_OFS, 8'h01);
        pkt(3, 1'b0);
        pkt(4, 1'b1);
        rdchk(dsc_pkg::STAT_OFS, 8'h02);
        rdchk(dsc_pkg::STAT_OFS, 8'h00);
        @(posedge ref_clk);
        rate_106k <= 1'b1;
        sync_detect_enable <= 1'b0;
        pkt(3, 1'b1);
        @(posedge ref_clk);
        sync_detect_enable <= 1'b1;
        pkt(3, 1'b0);
    endtask : t_pkt

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs;
        t_chan;
        t_misc;
        t_sync;
        t_pkt;
        complete_run;
    end
endmodule : dsc_core_tb
